// ==== hdl/program_space_access.sv ====
`timescale 1ns/1ps

// Functional notes
// - table page joined above effective address
// - table page bit 7 picks configuration space
// - table writes to configuration space refused
// - window read joins page low byte, address[14:0]
// - read page bit 8 picks upper word
// - window reads never reach configuration space
// - address bit 15 ignored, page bit 0 used
// - pages 0x200-0x3FF readable lower/upper words
// - page zero above 0x8000 traps
// - low word read, word mode passes P[15:0]
// - low byte mode picks byte by select
// - high word read zeroes phantom byte
// - high byte mode phantom byte reads zero
// - program counter steps by two, bit0 zero
// - window read costs one or two cycles
// - repeat loop window read cost rules
// - data address below 0x8000 ignores read and write pages
// - extended read address from 9 page bits
module program_space_access (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // page register writes from the core
  input wire logic tbl_page_we,
  input wire logic [program_space_pkg::TBL_PAGE_W-1:0] tbl_page_wdata,
  input wire logic rd_page_we,
  input wire logic [program_space_pkg::RD_PAGE_W-1:0] rd_page_wdata,
  input wire logic wr_page_we,
  input wire logic [program_space_pkg::WR_PAGE_W-1:0] wr_page_wdata,
  // page register contents
  output logic [program_space_pkg::TBL_PAGE_W-1:0] table_page_register,
  output logic [program_space_pkg::RD_PAGE_W-1:0] data_read_page_register,
  output logic [program_space_pkg::WR_PAGE_W-1:0] data_write_page_register,
  // program counter
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic [program_space_pkg::PROG_W-1:0] pc_target,
  output logic [program_space_pkg::PROG_W-1:0] fetch_addr,
  // access request from the core
  input wire logic req_valid,
  output logic req_ready,
  input wire program_space_pkg::access_kind_t req_kind,
  input wire logic [program_space_pkg::DATA_W-1:0] effective_address,
  input wire logic req_byte,
  input wire logic [program_space_pkg::DATA_W-1:0] req_wdata,
  // instruction context for cycle cost
  input wire logic instr_is_move,
  input wire logic rep_active,
  input wire logic rep_first,
  input wire logic rep_last,
  input wire logic rep_irq_exit,
  input wire logic rep_irq_reentry,
  // answer to the core
  output logic resp_done,
  output logic [program_space_pkg::DATA_W-1:0] resp_rdata,
  output logic addr_error_trap,
  output logic cfg_write_refused,
  // program flash side
  output logic prog_rd_en,
  output logic prog_wr_en,
  output logic prog_wr_upper,
  output logic prog_wr_byte,
  output logic prog_cfg_sel,
  output logic [program_space_pkg::PROG_W-1:0] prog_addr,
  output logic [program_space_pkg::DATA_W-1:0] prog_wdata,
  input wire logic [program_space_pkg::PROG_W-1:0] prog_rdata,
  // data memory side
  output logic data_rd_en,
  output logic data_wr_en,
  output logic data_wr_byte,
  output logic [program_space_pkg::PROG_W-1:0] data_addr,
  output logic [program_space_pkg::DATA_W-1:0] data_wdata,
  input wire logic [program_space_pkg::DATA_W-1:0] data_rdata
);
  import program_space_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ACCESS,
    S_EXTRA,
    S_DONE
  } state_t;

  // byte lane steering shared by table and window reads
  function automatic logic [DATA_W-1:0] steer(input logic [DATA_W-1:0] word,
                                              input logic byte_mode,
                                              input logic byte_sel);
    logic [DATA_W-1:0] res;
    res = word;
    if (byte_mode) begin
      res = byte_sel ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
    end
    return res;
  endfunction

  state_t state_q, state_d;
  logic [TBL_PAGE_W-1:0] tbl_page_q;
  logic [RD_PAGE_W-1:0] rd_page_q;
  logic [WR_PAGE_W-1:0] wr_page_q;
  logic [PROG_W-1:0] pc_q, pc_d;
  logic [EXTRA_W-1:0] extra_q, extra_d;
  access_kind_t kind_q;
  logic byte_q, bsel_q, win_q, upper_q;
  logic trap_q, refused_q;
  logic [DATA_W-1:0] rdata_q;
  logic prog_rd_q, prog_wr_q, prog_up_q, prog_byte_q, prog_cfg_q;
  logic [PROG_W-1:0] prog_addr_q, data_addr_q;
  logic [DATA_W-1:0] prog_wdata_q, data_wdata_q;
  logic data_rd_q, data_wr_q, data_byte_q;

  // request decode
  wire take = req_valid && (state_q == S_IDLE);
  wire hi_half = effective_address[ADDR_WINDOW_BIT];
  wire is_table = (req_kind != K_DATA_RD) && (req_kind != K_DATA_WR);
  wire is_tbl_wr = (req_kind == K_TBL_WR_LO) || (req_kind == K_TBL_WR_HI);
  wire is_tbl_hi = (req_kind == K_TBL_RD_HI) || (req_kind == K_TBL_WR_HI);
  wire tbl_cfg = tbl_page_q[TBL_CFG_BIT];
  wire rd_window = (req_kind == K_DATA_RD) && hi_half;
  wire win_prog = rd_window && rd_page_q[RD_PROG_BIT];
  wire win_upper = rd_page_q[RD_UPPER_BIT];

  // page zero in the upper half of data space is not backed by memory
  wire rd_trap = rd_window && (rd_page_q == '0);
  wire wr_trap = (req_kind == K_DATA_WR) && hi_half && (wr_page_q == '0);
  wire any_trap = rd_trap || wr_trap;
  wire refuse = is_tbl_wr && tbl_cfg;

  // program address forms
  wire [PROG_W-1:0] tbl_addr = {tbl_page_q, effective_address};
  // window path keeps bit 23 low so configuration space is unreachable
  wire [PROG_W-1:0] win_addr = {1'b0, rd_page_q[7:0], effective_address[14:0]};

  // data address forms; low half of data space bypasses both pages
  wire [PROG_W-1:0] low_addr = {8'h00, effective_address};
  wire [PROG_W-1:0] ext_rd_addr = {rd_page_q[8:0], effective_address[14:0]};
  wire [PROG_W-1:0] ext_wr_addr = {wr_page_q, effective_address[14:0]};

  // extra instruction cycles for a window read
  wire rep_edge = rep_first || rep_last || rep_irq_exit || rep_irq_reentry;
  wire [EXTRA_W-1:0] rep_cost = rep_edge ? EXTRA_OTHER : EXTRA_NONE;
  wire [EXTRA_W-1:0] plain_cost = instr_is_move ? EXTRA_MOVE : EXTRA_OTHER;
  wire [EXTRA_W-1:0] win_cost = rep_active ? rep_cost : plain_cost;

  // read steering from the sampled memories
  wire [DATA_W-1:0] prog_lo = prog_rdata[15:0];
  wire [DATA_W-1:0] prog_hi = {8'h00, prog_rdata[23:16]};
  wire tbl_rd_lo = (kind_q == K_TBL_RD_LO);
  wire tbl_rd_hi = (kind_q == K_TBL_RD_HI);
  wire [DATA_W-1:0] lo_data = steer(prog_lo, byte_q, bsel_q);
  // upper byte lane of a high read is the phantom byte, always zero
  wire [DATA_W-1:0] hi_data = steer(prog_hi, byte_q, bsel_q);
  wire [DATA_W-1:0] win_word = upper_q ? prog_hi : prog_lo;
  wire [DATA_W-1:0] win_data = steer(win_word, byte_q, bsel_q);
  wire [DATA_W-1:0] rd_sel = tbl_rd_lo ? lo_data :
                             tbl_rd_hi ? hi_data :
                             win_q ? win_data : data_rdata;
  wire capture = (state_q == S_ACCESS) && (prog_rd_q || data_rd_q);

  // program counter next value, bit 0 held low
  wire [PROG_W-1:0] pc_inc = pc_q + PC_STEP;
  assign pc_d = pc_load ? {pc_target[PROG_W-1:1], 1'b0} :
                pc_step ? {pc_inc[PROG_W-1:1], 1'b0} : pc_q;

  // page registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_page_q <= TBL_PAGE_RST;
      rd_page_q <= RD_PAGE_RST;
      wr_page_q <= WR_PAGE_RST;
    end else begin
      if (tbl_page_we) begin
        tbl_page_q <= tbl_page_wdata;
      end
      if (rd_page_we) begin
        rd_page_q <= rd_page_wdata;
      end
      if (wr_page_we) begin
        wr_page_q <= wr_page_wdata;
      end
    end
  end

  // program counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // sequencing: take, one access cycle, extra cycles, answer
  always_comb begin
    state_d = state_q;
    extra_d = extra_q;
    case (state_q)
      S_IDLE: begin
        if (take) begin
          // a trapped or refused access skips memory entirely
          state_d = (any_trap || refuse) ? S_DONE : S_ACCESS;
          extra_d = win_prog ? win_cost : EXTRA_NONE;
        end
      end
      S_ACCESS: begin
        state_d = (extra_q == EXTRA_NONE) ? S_DONE : S_EXTRA;
      end
      S_EXTRA: begin
        extra_d = extra_q - 2'h1;
        if (extra_q == 2'h1) begin
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      extra_q <= EXTRA_NONE;
    end else begin
      state_q <= state_d;
      extra_q <= extra_d;
    end
  end

  // request context held for the steering stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_q <= K_DATA_RD;
      byte_q <= 1'b0;
      bsel_q <= 1'b0;
      win_q <= 1'b0;
      upper_q <= 1'b0;
    end else if (take) begin
      kind_q <= req_kind;
      byte_q <= req_byte;
      bsel_q <= effective_address[0];
      win_q <= win_prog;
      upper_q <= win_upper;
    end
  end

  // one-cycle event flags, raised for the answer cycle only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      trap_q <= take && any_trap;
      refused_q <= take && refuse;
    end
  end

  // program flash strobes, one cycle wide
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_rd_q <= 1'b0;
      prog_wr_q <= 1'b0;
      prog_up_q <= 1'b0;
      prog_byte_q <= 1'b0;
      prog_cfg_q <= 1'b0;
      prog_addr_q <= '0;
      prog_wdata_q <= '0;
    end else begin
      prog_rd_q <= take && !any_trap && (win_prog || (is_table && !is_tbl_wr));
      prog_wr_q <= take && is_tbl_wr && !refuse;
      if (take) begin
        prog_up_q <= is_tbl_hi;
        prog_byte_q <= req_byte;
        prog_cfg_q <= is_table && tbl_cfg;
        prog_addr_q <= is_table ? tbl_addr : win_addr;
        prog_wdata_q <= req_wdata;
      end
    end
  end

  // data memory strobes; trapped accesses never reach memory
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_rd_q <= 1'b0;
      data_wr_q <= 1'b0;
      data_byte_q <= 1'b0;
      data_addr_q <= '0;
      data_wdata_q <= '0;
    end else begin
      data_rd_q <= take && (req_kind == K_DATA_RD) && !win_prog && !rd_trap;
      data_wr_q <= take && (req_kind == K_DATA_WR) && !wr_trap;
      if (take) begin
        data_byte_q <= req_byte;
        data_wdata_q <= req_wdata;
        if (!hi_half) begin
          data_addr_q <= low_addr;
        end else if (req_kind == K_DATA_WR) begin
          data_addr_q <= ext_wr_addr;
        end else begin
          data_addr_q <= ext_rd_addr;
        end
      end
    end
  end

  // read data captured at the end of the access cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (take) begin
      rdata_q <= '0;
    end else if (capture) begin
      rdata_q <= rd_sel;
    end
  end

  // outputs
  assign req_ready = (state_q == S_IDLE);
  assign resp_done = (state_q == S_DONE);
  assign resp_rdata = rdata_q;
  assign addr_error_trap = trap_q;
  assign cfg_write_refused = refused_q;
  assign table_page_register = tbl_page_q;
  assign data_read_page_register = rd_page_q;
  assign data_write_page_register = wr_page_q;
  assign fetch_addr = {1'b0, pc_q[22:1], 1'b0};
  assign prog_rd_en = prog_rd_q;
  assign prog_wr_en = prog_wr_q;
  assign prog_wr_upper = prog_up_q;
  assign prog_wr_byte = prog_byte_q;
  assign prog_cfg_sel = prog_cfg_q;
  assign prog_addr = prog_addr_q;
  assign prog_wdata = prog_wdata_q;
  assign data_rd_en = data_rd_q;
  assign data_wr_en = data_wr_q;
  assign data_wr_byte = data_byte_q;
  assign data_addr = data_addr_q;
  assign data_wdata = data_wdata_q;

endmodule

// ==== hdl/program_space_pkg.sv ====
package program_space_pkg;

  // widths of the address and data paths
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int TBL_PAGE_W = 8;
  localparam int RD_PAGE_W = 10;
  localparam int WR_PAGE_W = 9;
  localparam int EXTRA_W = 2;

  // page register fields and the address window bit
  localparam int TBL_CFG_BIT = 7;
  localparam int RD_PROG_BIT = 9;
  localparam int RD_UPPER_BIT = 8;
  localparam int ADDR_WINDOW_BIT = 15;

  // reset values
  localparam logic [TBL_PAGE_W-1:0] TBL_PAGE_RST = 8'h00;
  localparam logic [RD_PAGE_W-1:0] RD_PAGE_RST = 10'h001;
  localparam logic [WR_PAGE_W-1:0] WR_PAGE_RST = 9'h001;
  localparam logic [PROG_W-1:0] PC_RST = 24'h00_0000;

  // program counter step per program word
  localparam logic [PROG_W-1:0] PC_STEP = 24'h00_0002;

  // extra instruction cycles of a window read
  localparam logic [EXTRA_W-1:0] EXTRA_NONE = 2'h0;
  localparam logic [EXTRA_W-1:0] EXTRA_MOVE = 2'h1;
  localparam logic [EXTRA_W-1:0] EXTRA_OTHER = 2'h2;

  // kinds of access presented by the core
  typedef enum logic [2:0] {
    K_DATA_RD,
    K_DATA_WR,
    K_TBL_RD_LO,
    K_TBL_RD_HI,
    K_TBL_WR_LO,
    K_TBL_WR_HI
  } access_kind_t;

endpackage

// ==== verification/mem_model.sv ====
`timescale 1ns/1ps

// program flash and data memory behind the access block
module mem_model (
  // clock
  input wire logic sys_clk,
  // flash side
  input wire logic prog_rd_en,
  input wire logic [23:0] prog_addr,
  output logic [23:0] prog_rdata,
  // data memory side
  input wire logic data_rd_en,
  input wire logic [23:0] data_addr,
  output logic [15:0] data_rdata
);
  logic [23:0] junk_q = 24'h55_5555;

  // idle buses churn so a stale value never passes
  always @(posedge sys_clk) junk_q <= ~junk_q;

  // data only while the read strobe stands
  assign prog_rdata = prog_rd_en ? {prog_addr[23:16] ^ 8'h3c, prog_addr[15:0] ^ 16'ha5c3} : junk_q;
  assign data_rdata = data_rd_en ? data_addr[15:0] ^ {data_addr[23:16], 8'h3c} : junk_q[15:0];
endmodule

// ==== verification/psa_props.sv ====
`timescale 1ns/1ps

// watches the access block from its ports only
module psa_props import program_space_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pages and program counter
  input wire logic [7:0] table_page_register,
  input wire logic [9:0] data_read_page_register,
  input wire logic pc_step,
  input wire logic pc_load,
  input wire logic [23:0] pc_target,
  input wire logic [23:0] fetch_addr,
  // request from the core
  input wire logic req_valid,
  input wire logic req_ready,
  input wire access_kind_t req_kind,
  input wire logic [15:0] effective_address,
  input wire logic instr_is_move,
  input wire logic rep_active,
  // answer and memory strobes
  input wire logic resp_done,
  input wire logic addr_error_trap,
  input wire logic cfg_write_refused,
  input wire logic prog_rd_en,
  input wire logic prog_wr_en,
  input wire logic prog_cfg_sel,
  input wire logic [23:0] prog_addr,
  input wire logic data_rd_en,
  input wire logic data_wr_en,
  input wire logic [23:0] data_addr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // taken requests sorted by path
  wire take = req_valid && req_ready;
  wire rd = take && req_kind == K_DATA_RD;
  wire win = rd && effective_address[15] && data_read_page_register[9];
  wire tbl = take && (req_kind == K_TBL_RD_LO || req_kind == K_TBL_RD_HI);

  AST_TRAP_HOLD: assert property (
    addr_error_trap |-> resp_done && !data_wr_en && !data_rd_en && !prog_rd_en)
    else $error("trap without done or with an access");
  AST_REFUSE: assert property (
    cfg_write_refused |-> resp_done && !prog_wr_en)
    else $error("refusal without done or with a write");
  AST_CFG_NO_WR: assert property (prog_wr_en |-> !prog_cfg_sel)
    else $error("flash write into configuration space");
  AST_PC_STEP: assert property (
    pc_step && !pc_load |=> fetch_addr == $past(fetch_addr) + PC_STEP)
    else $error("fetch address did not step by two");
  AST_PC_LOAD: assert property (
    pc_load |=> fetch_addr == {1'b0, $past(pc_target[22:1]), 1'b0})
    else $error("fetch address load wrong");
  AST_TBL_ADDR: assert property (tbl |=> prog_rd_en
    && prog_addr == {$past(table_page_register), $past(effective_address)}
    && prog_cfg_sel == $past(table_page_register[7])) else $error("table address wrong");
  AST_WIN_ADDR: assert property (win |=> prog_rd_en && !prog_cfg_sel
    && prog_addr == {1'b0, $past(data_read_page_register[7:0]), $past(effective_address[14:0])})
    else $error("window address wrong");
  AST_WIN_MOVE: assert property (
    win && instr_is_move && !rep_active |=> !resp_done [*2] ##1 resp_done)
    else $error("move window read cost wrong");
  AST_WIN_OTHER: assert property (
    win && !instr_is_move && !rep_active |=> !resp_done [*3] ##1 resp_done)
    else $error("other window read cost wrong");
  AST_PAGE0: assert property (
    rd && effective_address[15] && data_read_page_register == 10'h000 |=> addr_error_trap)
    else $error("page zero read did not trap");
  AST_LOW_ADDR: assert property (rd && !effective_address[15] |=> data_rd_en
    && !addr_error_trap && data_addr == {8'h00, $past(effective_address)})
    else $error("low data read wrong");

  // main scenarios reached
  COV_WIN: cover property (win);
  COV_TRAP: cover property (addr_error_trap);
  COV_REFUSE: cover property (cfg_write_refused);
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps

module tb;
  import program_space_pkg::*;
  logic sys_clk, rst_n, tbl_page_we, rd_page_we, wr_page_we, pc_step, pc_load;
  logic [7:0] tbl_page_wdata, table_page_register;
  logic [9:0] rd_page_wdata, data_read_page_register;
  logic [8:0] wr_page_wdata, data_write_page_register;
  logic [23:0] pc_target, fetch_addr, prog_addr, prog_rdata, data_addr, got, p, wa;
  logic req_valid, req_ready, req_byte, instr_is_move, rep_active, rep_first, rep_last;
  logic rep_irq_exit, rep_irq_reentry, resp_done, addr_error_trap, cfg_write_refused;
  logic prog_rd_en, prog_wr_en, prog_wr_upper, prog_wr_byte, prog_cfg_sel, trap, refused;
  logic data_rd_en, data_wr_en, data_wr_byte;
  logic [15:0] effective_address, req_wdata, resp_rdata, prog_wdata, data_wdata, data_rdata, wd;
  logic [4:0] wstb;
  access_kind_t req_kind;
  int n_errors = 0;
  int num_checks = 0;
  int cyc;

  program_space_access i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .tbl_page_we(tbl_page_we),
    .tbl_page_wdata(tbl_page_wdata), .rd_page_we(rd_page_we), .rd_page_wdata(rd_page_wdata),
    .wr_page_we(wr_page_we), .wr_page_wdata(wr_page_wdata),
    .table_page_register(table_page_register),
    .data_read_page_register(data_read_page_register),
    .data_write_page_register(data_write_page_register),
    .pc_step(pc_step), .pc_load(pc_load), .pc_target(pc_target), .fetch_addr(fetch_addr),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .effective_address(effective_address), .req_byte(req_byte), .req_wdata(req_wdata),
    .instr_is_move(instr_is_move), .rep_active(rep_active), .rep_first(rep_first),
    .rep_last(rep_last), .rep_irq_exit(rep_irq_exit), .rep_irq_reentry(rep_irq_reentry),
    .resp_done(resp_done), .resp_rdata(resp_rdata), .addr_error_trap(addr_error_trap),
    .cfg_write_refused(cfg_write_refused), .prog_rd_en(prog_rd_en), .prog_wr_en(prog_wr_en),
    .prog_wr_upper(prog_wr_upper), .prog_wr_byte(prog_wr_byte), .prog_cfg_sel(prog_cfg_sel),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .data_wr_byte(data_wr_byte),
    .data_addr(data_addr), .data_wdata(data_wdata), .data_rdata(data_rdata)
  );
  mem_model i_mem (
    .sys_clk(sys_clk), .prog_rd_en(prog_rd_en), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .data_rd_en(data_rd_en), .data_addr(data_addr), .data_rdata(data_rdata)
  );

  // free running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // flash contents as the model presents them
  function automatic logic [23:0] pf(input logic [23:0] a);
    return {a[23:16] ^ 8'h3c, a[15:0] ^ 16'ha5c3};
  endfunction

  // all three pages written in one edge
  task automatic pages(input logic [7:0] t, input logic [9:0] r, input logic [8:0] w);
    tbl_page_wdata = t;
    rd_page_wdata = r;
    wr_page_wdata = w;
    {tbl_page_we, rd_page_we, wr_page_we} = 3'h7;
    @(posedge sys_clk);
    #1 {tbl_page_we, rd_page_we, wr_page_we} = 3'h0;
  endtask

  // one access; cyc counts cycles from take to done
  task automatic req(input access_kind_t k, input logic [15:0] ea, input logic b);
    req_kind = k;
    effective_address = ea;
    req_byte = b;
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1 req_valid = 1'b0;
    cyc = 1;
    // write strobes stand only in the cycle after the take
    wstb = {prog_wr_en, prog_wr_upper, prog_wr_byte, data_wr_en, data_wr_byte};
    wd = prog_wr_en ? prog_wdata : data_wdata;
    wa = prog_wr_en ? prog_addr : data_addr;
    while (resp_done !== 1'b1 && cyc < 20) begin
      @(posedge sys_clk);
      #1 cyc++;
    end
    // a lost answer ends the run rather than checking stale values
    if (resp_done !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t request never answered", $time);
      end_sim;
    end
    got = {8'h00, resp_rdata};
    trap = addr_error_trap;
    refused = cfg_write_refused;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic t_table;
    pages(8'h12, 10'h001, 9'h001);
    p = pf(24'h12_3456);
    req(K_TBL_RD_LO, 16'h3456, 1'b0);
    chk(got, 24'(p[15:0]));
    chk(24'(cyc), 24'h2);
    req(K_TBL_RD_LO, 16'h3456, 1'b1);
    chk(got, 24'(p[7:0]));
    req(K_TBL_RD_HI, 16'h3456, 1'b0);
    chk(got, 24'(p[23:16]));
    req(K_TBL_RD_HI, 16'h3456, 1'b1);
    chk(got, 24'(p[23:16]));
    p = pf(24'h12_3457);
    req(K_TBL_RD_LO, 16'h3457, 1'b1);
    chk(got, 24'(p[15:8]));
    req(K_TBL_RD_HI, 16'h3457, 1'b1);
    chk(got, 24'h00_0000);
    req(K_TBL_WR_LO, 16'h3456, 1'b0);
    chk(24'(refused), 24'h0);
    chk(24'(wstb[4:1]), 24'h8);
    chk(wa, 24'h12_3456);
    chk(24'(wd), 24'h1234);
    req(K_TBL_WR_HI, 16'h3457, 1'b1);
    chk(24'(wstb[4:1]), 24'he);
    chk(wa, 24'h12_3457);
  endtask

  // configuration page: reads pass, writes refused
  task automatic t_cfg;
    pages(8'h80, 10'h001, 9'h001);
    chk(24'(table_page_register), 24'h80);
    req(K_TBL_RD_LO, 16'h0004, 1'b0);
    chk(got, 24'(pf(24'h80_0004) & 24'h00_ffff));
    req(K_TBL_WR_LO, 16'h0004, 1'b0);
    chk(24'(refused), 24'h1);
    req(K_TBL_WR_HI, 16'h0004, 1'b0);
    chk(24'(refused), 24'h1);
    chk(24'(wstb[4]), 24'h0);
  endtask

  task automatic t_window;
    pages(8'h00, 10'h202, 9'h001);
    chk(24'(data_read_page_register), 24'h202);
    instr_is_move = 1'b1;
    req(K_DATA_RD, 16'h800a, 1'b0);
    chk(got, pf(24'h01_000a) & 24'h00_ffff);
    chk(24'(cyc), 24'h3);
    pages(8'h00, 10'h303, 9'h001);
    instr_is_move = 1'b0;
    req(K_DATA_RD, 16'hc000, 1'b0);
    chk(got, 24'(pf(24'h01_c000) >> 16));
    chk(24'(cyc), 24'h4);
    rep_active = 1'b1;
    for (int i = 0; i < 5; i++) begin
      {rep_first, rep_last, rep_irq_exit, rep_irq_reentry} = 4'h8 >> i;
      req(K_DATA_RD, 16'hc000, 1'b0);
      chk(24'(cyc), (i < 4) ? 24'h4 : 24'h2);
    end
    rep_active = 1'b0;
  endtask

  task automatic t_trap;
    pages(8'h00, 10'h000, 9'h000);
    chk(24'(data_write_page_register), 24'h0);
    req(K_DATA_RD, 16'h8000, 1'b0);
    chk(24'(trap), 24'h1);
    chk(24'(cyc), 24'h1);
    req(K_DATA_WR, 16'hfffe, 1'b0);
    chk(24'(trap), 24'h1);
    req(K_DATA_RD, 16'h7ffe, 1'b0);
    chk(got, 24'h00_7fc2);
    pages(8'h00, 10'h005, 9'h001);
    req(K_DATA_RD, 16'h8004, 1'b0);
    chk(got, 24'h00_8238);
    // low half write must ignore the nonzero write page
    req_wdata = 16'h5aa5;
    req(K_DATA_WR, 16'h1000, 1'b1);
    chk(24'({wstb[4], wstb[1:0]}), 24'h3);
    chk(wa, 24'h00_1000);
    chk(24'(wd), 24'h5aa5);
  endtask

  task automatic t_pc;
    pc_target = 24'h81_2345;
    pc_load = 1'b1;
    @(posedge sys_clk);
    #1 pc_load = 1'b0;
    chk(fetch_addr, 24'h01_2344);
    pc_step = 1'b1;
    @(posedge sys_clk);
    #1 pc_step = 1'b0;
    chk(fetch_addr, 24'h01_2346);
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    {tbl_page_we, rd_page_we, wr_page_we, pc_step, pc_load, req_valid, req_byte} = '0;
    {instr_is_move, rep_active, rep_first, rep_last, rep_irq_exit, rep_irq_reentry} = '0;
    {tbl_page_wdata, rd_page_wdata, wr_page_wdata, pc_target} = '0;
    req_kind = K_DATA_RD;
    effective_address = 16'h0000;
    req_wdata = 16'h1234;
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_table;
    t_cfg;
    t_window;
    t_trap;
    t_pc;
    end_sim;
  end

  // hang guard, far beyond the fewer than one hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
endmodule

bind program_space_access psa_props i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .table_page_register(table_page_register),
  .data_read_page_register(data_read_page_register), .pc_step(pc_step), .pc_load(pc_load),
  .pc_target(pc_target), .fetch_addr(fetch_addr), .req_valid(req_valid),
  .req_ready(req_ready), .req_kind(req_kind), .effective_address(effective_address),
  .instr_is_move(instr_is_move), .rep_active(rep_active), .resp_done(resp_done),
  .addr_error_trap(addr_error_trap), .cfg_write_refused(cfg_write_refused),
  .prog_rd_en(prog_rd_en), .prog_wr_en(prog_wr_en), .prog_cfg_sel(prog_cfg_sel),
  .prog_addr(prog_addr), .data_rd_en(data_rd_en), .data_wr_en(data_wr_en),
  .data_addr(data_addr)
);
